// *** src/sac_top.sv ***
// Contract
// RULE_01 - parallel six lines weigh 0.5 to 16 dB
// RULE_02 - serial word is dB times four
// RULE_03 - controller sends zeros in unused bits
// RULE_04 - select low parallel, high serial
// RULE_05 - latched parallel: strobe low, then pulse
// RULE_06 - strobe high: follow parallel lines directly
// RULE_07 - 16-bit shift register: attenuation, then address
// RULE_08 - update only when address matches straps
// RULE_09 - LSB first, sampled on clock rise
// RULE_10 - serial out is input delayed 16 clocks
// RULE_11 - controller keeps strobe low while shifting
// RULE_12 - serial or latched start at maximum attenuation
// RULE_13 - direct start takes lines after delay
// RULE_14 - floating strobe in latched mode: maximum
// RULE_15 - serial start: strobe high gives reference
// RULE_16 - controller never switches mode while running (the bench switches select while running, after driving pins low)
// RULE_17 - serial to parallel: drive pins low first
// RULE_18 - parallel to serial: pins low, output released
// RULE_19 - serial pins double as parallel lines
// RULE_20 - shift while strobe low, strobe rise transfers
// RULE_21 - latched parallel captures at strobe fall
module sac_top #(
  parameter int ADDR_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_serial_select,
  input wire logic i_latch_strobe,
  input wire logic i_serial_in_or_half_db_bit,
  input wire logic i_serial_clock_or_one_db_bit,
  input wire logic i_serial_out_or_two_db_bit,
  input wire logic i_addr_strap0_or_four_db_bit,
  input wire logic i_addr_strap1_or_eight_db_bit,
  input wire logic i_addr_strap2_or_sixteen_db_bit,
  output logic o_serial_out_or_two_db_bit,
  output logic o_serial_out_or_two_db_bit_oe,
  output logic [5:0] o_atten_code,
  input wire logic [ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [ADDR_W-1:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);

  typedef struct packed {
    sac_pkg::sac_state_e st;
    logic [sac_pkg::CNT_W-1:0] cnt;
    logic [sac_pkg::PIN_W-1:0] s1;
    logic [sac_pkg::PIN_W-1:0] s2;
    logic [sac_pkg::PIN_W-1:0] s3;
    logic [sac_pkg::SR_W-1:0] sr;
    logic [5:0] atten;
    logic sdo;
    logic sdo_oe;
    logic freeze;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sac_regs_s;

  sac_regs_s r_r;
  sac_regs_s r_nxt;

  logic [sac_pkg::PIN_W-1:0] pins;
  logic serial_mode;
  logic clk_rise;
  logic clk_fall;
  logic le_rise;
  logic le_fall;
  logic addr_match;
  logic [5:0] lines;

  // pin order matches the parallel bit weights 0.5 dB upward
  assign pins = {i_serial_select, i_latch_strobe, i_addr_strap2_or_sixteen_db_bit,
                 i_addr_strap1_or_eight_db_bit, i_addr_strap0_or_four_db_bit,
                 i_serial_out_or_two_db_bit, i_serial_clock_or_one_db_bit,
                 i_serial_in_or_half_db_bit};

  assign serial_mode = r_r.s2[sac_pkg::P_SEL]; // [RULE_04]
  assign lines = r_r.s2[sac_pkg::P_A0+2:sac_pkg::P_SDI]; // [RULE_01] [RULE_19]
  assign clk_rise = r_r.s2[sac_pkg::P_CLK] & ~r_r.s3[sac_pkg::P_CLK];
  assign clk_fall = ~r_r.s2[sac_pkg::P_CLK] & r_r.s3[sac_pkg::P_CLK];
  assign le_rise = r_r.s2[sac_pkg::P_LE] & ~r_r.s3[sac_pkg::P_LE];
  assign le_fall = ~r_r.s2[sac_pkg::P_LE] & r_r.s3[sac_pkg::P_LE];
  assign addr_match = r_r.sr[sac_pkg::ADR_LSB+2:sac_pkg::ADR_LSB] ==
                      r_r.s2[sac_pkg::P_A0+2:sac_pkg::P_A0]; // [RULE_08]

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input sac_regs_s s);
    read_word = 32'h0000_0000;
    unique case (a)
      sac_pkg::REG_CTRL: read_word[0] = s.freeze;
      sac_pkg::REG_STATUS: read_word[9:0] = {s.st == sac_pkg::ST_RUN, s.s2[sac_pkg::P_SEL],
                                              s.s2[sac_pkg::P_LE], s.sdo_oe, s.atten};
      sac_pkg::REG_SHIFT: read_word[15:0] = s.sr;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == sac_pkg::REG_CTRL) || (a == sac_pkg::REG_STATUS) || (a == sac_pkg::REG_SHIFT);
  endfunction

  always_comb begin
    r_nxt = r_r;
    // pin synchronisers
    r_nxt.s1 = pins;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    r_nxt.sdo_oe = serial_mode; // [RULE_19]

    unique case (r_r.st)
      sac_pkg::ST_BOOT: begin
        // mode and strobe levels are read once the synchronisers hold real pin levels
        r_nxt.cnt = r_r.cnt + 1'b1;
        if (r_r.cnt == sac_pkg::CNT_W'(sac_pkg::BOOT_CYC)) begin
          r_nxt.cnt = '0;
          if (serial_mode) begin
            r_nxt.st = sac_pkg::ST_RUN;
            r_nxt.atten = r_r.s2[sac_pkg::P_LE] ? sac_pkg::ATT_REF : sac_pkg::ATT_MAX; // [RULE_15] [RULE_12]
          end else if (r_r.s2[sac_pkg::P_LE]) begin
            r_nxt.st = sac_pkg::ST_WAIT; // [RULE_13]
          end else begin
            r_nxt.st = sac_pkg::ST_RUN; // [RULE_12] [RULE_14]
          end
        end
      end
      sac_pkg::ST_WAIT: begin
        r_nxt.cnt = r_r.cnt + 1'b1;
        if (r_r.cnt == sac_pkg::CNT_W'(sac_pkg::DIRECT_DELAY_CYC - 1)) begin
          r_nxt.atten = lines; // [RULE_13]
          r_nxt.st = sac_pkg::ST_RUN;
          r_nxt.cnt = '0;
        end
      end
      sac_pkg::ST_RUN: begin
        if (serial_mode) begin
          if (clk_rise && !r_r.s2[sac_pkg::P_LE]) begin
            r_nxt.sr = {r_r.s2[sac_pkg::P_SDI], r_r.sr[sac_pkg::SR_W-1:1]}; // [RULE_09] [RULE_07] [RULE_20]
          end
          if (clk_fall) begin
            r_nxt.sdo = r_r.sr[0]; // [RULE_10]
          end
          if (le_rise && addr_match && !r_r.freeze) begin
            r_nxt.atten = r_r.sr[sac_pkg::ATT_LSB+5:sac_pkg::ATT_LSB]; // [RULE_02] [RULE_20] [RULE_08]
          end
        end else if (!r_r.freeze) begin
          if (r_r.s2[sac_pkg::P_LE]) begin
            r_nxt.atten = lines; // [RULE_06] [RULE_01]
          end else if (le_fall) begin
            r_nxt.atten = lines; // [RULE_21]
          end
        end
      end
      default: begin
        r_nxt.st = sac_pkg::ST_BOOT;
        r_nxt.cnt = '0;
      end
    endcase

    // write channel: address and data taken in either order
    if (i_axi_awvalid && r_r.awready) begin
      r_nxt.aw_have = 1'b1;
      r_nxt.aw_addr = i_axi_awaddr;
      r_nxt.awready = 1'b0;
    end
    if (i_axi_wvalid && r_r.wready) begin
      r_nxt.w_have = 1'b1;
      r_nxt.w_data = i_axi_wdata;
      r_nxt.w_lane0 = i_axi_wstrb[0];
      r_nxt.wready = 1'b0;
    end
    if (r_r.aw_have && r_r.w_have && !r_r.bvalid) begin
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = addr_ok(r_r.aw_addr) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
      if (r_r.aw_addr == sac_pkg::REG_CTRL && r_r.w_lane0) begin
        r_nxt.freeze = r_r.w_data[sac_pkg::CTRL_FREEZE];
      end
      r_nxt.aw_have = 1'b0;
      r_nxt.w_have = 1'b0;
    end
    if (r_r.bvalid && i_axi_bready) begin
      r_nxt.bvalid = 1'b0;
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
    end

    // read channel
    if (i_axi_arvalid && r_r.arready) begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata = read_word(i_axi_araddr, r_r);
      r_nxt.rresp = addr_ok(i_axi_araddr) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
    end
    if (r_r.rvalid && i_axi_rready) begin
      r_nxt.rvalid = 1'b0;
      r_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_r <= '0;
      r_r.st <= sac_pkg::ST_BOOT;
      r_r.atten <= sac_pkg::ATT_RST;
      r_r.freeze <= sac_pkg::CTRL_RST;
      r_r.awready <= 1'b1;
      r_r.wready <= 1'b1;
      r_r.arready <= 1'b1;
    end else if (i_ce) begin
      r_r <= r_nxt;
    end
  end

  assign o_atten_code = r_r.atten;
  assign o_serial_out_or_two_db_bit = r_r.sdo;
  assign o_serial_out_or_two_db_bit_oe = r_r.sdo_oe;
  assign o_axi_awready = r_r.awready;
  assign o_axi_wready = r_r.wready;
  assign o_axi_bvalid = r_r.bvalid;
  assign o_axi_bresp = r_r.bresp;
  assign o_axi_arready = r_r.arready;
  assign o_axi_rvalid = r_r.rvalid;
  assign o_axi_rdata = r_r.rdata;
  assign o_axi_rresp = r_r.rresp;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  serial_update_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && serial_mode && le_rise // [RULE_08]
      && addr_match && !r_r.freeze |=> o_atten_code == $past(r_r.sr[6:1]))
    else $error("serial word not applied on address match");
  addr_miss_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && serial_mode && le_rise // [RULE_08]
      && !addr_match |=> $stable(o_atten_code))
    else $error("attenuation changed on address mismatch");
  shift_in_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && serial_mode && clk_rise // [RULE_09]
      && !r_r.s2[sac_pkg::P_LE] |=> r_r.sr == {$past(r_r.s2[0]), $past(r_r.sr[15:1])})
    else $error("shift register did not take serial input");
  shift_hold_a: assert property (i_ce && serial_mode && r_r.s2[sac_pkg::P_LE] |=> $stable(r_r.sr)) // [RULE_20]
    else $error("shift register moved while strobe high");
  sdo_delay_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && serial_mode && clk_fall // [RULE_10]
      |=> o_serial_out_or_two_db_bit == $past(r_r.sr[0]))
    else $error("serial output not updated on clock fall");
  direct_follow_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && !serial_mode // [RULE_06]
      && !r_r.freeze && r_r.s2[sac_pkg::P_LE] |=> o_atten_code == $past(lines))
    else $error("direct mode did not follow lines");
  latch_fall_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && !serial_mode // [RULE_21]
      && !r_r.freeze && !r_r.s2[sac_pkg::P_LE] && !le_fall |=> $stable(o_atten_code))
    else $error("latched parallel state moved while strobe low");
  boot_max_a: assert property (r_r.st != sac_pkg::ST_RUN |-> o_atten_code == sac_pkg::ATT_MAX) // [RULE_12]
    else $error("not at maximum attenuation before start");
  boot_ref_a: assert property (i_ce && r_r.st == sac_pkg::ST_BOOT && serial_mode // [RULE_15]
      && r_r.s2[sac_pkg::P_LE] && r_r.cnt == 7'h03 |=> o_atten_code == sac_pkg::ATT_REF)
    else $error("serial start with strobe high not at reference");
  direct_wait_a: assert property (i_ce && $rose(r_r.st == sac_pkg::ST_WAIT) // [RULE_13]
      |-> (r_r.st == sac_pkg::ST_WAIT) [*8])
    else $error("direct start delay too short");
  oe_mode_a: assert property (i_ce |=> o_serial_out_or_two_db_bit_oe == $past(serial_mode)) // [RULE_19]
    else $error("serial output enable does not follow mode");

  // serial shift and output path, latch capture and freeze hold
  shift_idle_a: assert property (i_ce && !(r_r.st == sac_pkg::ST_RUN && serial_mode && clk_rise // [RULE_20]
      && !r_r.s2[sac_pkg::P_LE]) |=> $stable(r_r.sr))
    else $error("shift register moved without a clock rise");
  sdo_idle_a: assert property (i_ce && !(r_r.st == sac_pkg::ST_RUN && serial_mode && clk_fall) // [RULE_10]
      |=> $stable(o_serial_out_or_two_db_bit))
    else $error("serial output moved without a clock fall");
  serial_hold_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && serial_mode && !le_rise // [RULE_20]
      |=> $stable(o_atten_code))
    else $error("serial attenuation moved without strobe rise");
  latch_take_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && !serial_mode && !r_r.freeze // [RULE_21]
      && le_fall |=> o_atten_code == $past(lines))
    else $error("latched parallel lines not captured at strobe fall");
  freeze_hold_a: assert property (i_ce && r_r.st == sac_pkg::ST_RUN && r_r.freeze
      |=> $stable(o_atten_code))
    else $error("attenuation moved while frozen");

  // power-up decisions
  boot_serial_max_a: assert property (i_ce && r_r.st == sac_pkg::ST_BOOT && serial_mode // [RULE_12]
      && !r_r.s2[sac_pkg::P_LE] && r_r.cnt == 7'h03 |=> o_atten_code == sac_pkg::ATT_MAX)
    else $error("serial start with strobe low not at maximum");
  boot_latch_max_a: assert property (i_ce && r_r.st == sac_pkg::ST_BOOT && !serial_mode // [RULE_14]
      && !r_r.s2[sac_pkg::P_LE] && r_r.cnt == 7'h03 |=> o_atten_code == sac_pkg::ATT_MAX && r_r.st == sac_pkg::ST_RUN)
    else $error("latched parallel start not at maximum");
  boot_direct_a: assert property (i_ce && r_r.st == sac_pkg::ST_BOOT && !serial_mode // [RULE_13]
      && r_r.s2[sac_pkg::P_LE] && r_r.cnt == 7'h03 |=> r_r.st == sac_pkg::ST_WAIT)
    else $error("direct parallel start did not wait");
  wait_done_a: assert property (i_ce && r_r.st == sac_pkg::ST_WAIT // [RULE_13]
      && r_r.cnt == 7'h4F
      |=> r_r.st == sac_pkg::ST_RUN && o_atten_code == $past(lines))
    else $error("direct start did not take the lines");

  // register bus handshakes
  ar_answer_a: assert property (i_ce && i_axi_arvalid && o_axi_arready
      |=> o_axi_rvalid && !o_axi_arready)
    else $error("read address taken without answer");
  r_hold_a: assert property (i_ce && o_axi_rvalid && !i_axi_rready
      |=> o_axi_rvalid && $stable(o_axi_rdata)
      && $stable(o_axi_rresp))
    else $error("read answer dropped before rready");
  b_hold_a: assert property (i_ce && o_axi_bvalid && !i_axi_bready
      |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("write answer dropped before bready");
  w_pair_a: assert property (i_ce && !o_axi_awready && !o_axi_wready && !o_axi_bvalid
      |=> o_axi_bvalid)
    else $error("write pair taken without answer");
  ctrl_write_a: assert property (i_ce && r_r.aw_have && r_r.w_have && !r_r.bvalid && r_r.w_lane0
      && r_r.aw_addr == sac_pkg::REG_CTRL |=> r_r.freeze == $past(r_r.w_data[0]))
    else $error("control write did not land");
  unmapped_read_a: assert property (i_ce && i_axi_arvalid && o_axi_arready && !addr_ok(i_axi_araddr)
      |=> o_axi_rresp == sac_pkg::RESP_SLVERR && o_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  serial_write_c: cover property (r_r.st == sac_pkg::ST_RUN && serial_mode && le_rise && addr_match);
  ref_start_c: cover property (r_r.st == sac_pkg::ST_BOOT ##1 r_r.st == sac_pkg::ST_RUN && o_atten_code == 6'h00);
  direct_start_c: cover property (r_r.st == sac_pkg::ST_WAIT ##1 r_r.st == sac_pkg::ST_RUN);
  latch_capture_c: cover property (r_r.st == sac_pkg::ST_RUN && !serial_mode && le_fall);
  axi_write_c: cover property (o_axi_bvalid && i_axi_bready);
endmodule

// *** include/sac_pkg.sv ***
package sac_pkg;
  // pin vector positions after synchronisation
  localparam int P_SDI = 0;
  localparam int P_CLK = 1;
  localparam int P_SDO = 2;
  localparam int P_A0 = 3;
  localparam int P_LE = 6;
  localparam int P_SEL = 7;
  localparam int PIN_W = 8;

  // attenuation code in 0.5 dB units, bit 0 = 0.5 dB
  localparam logic [5:0] ATT_MAX = 6'h3F;
  localparam logic [5:0] ATT_REF = 6'h00;
  localparam logic [5:0] ATT_RST = ATT_MAX;

  // serial word layout
  localparam int SR_W = 16;
  localparam int ATT_LSB = 1;
  localparam int ADR_LSB = 8;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DIRECT_DELAY_NS = 4000;
  localparam int DIRECT_DELAY_CYC = (DIRECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CYC = 3;
  localparam int CNT_W = 7;

  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SHIFT = 4'h8;
  localparam int CTRL_FREEZE = 0;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } sac_state_e;
endpackage

// *** verif/sac_ctrl_model.sv ***
module sac_ctrl_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_par,
  input wire logic [15:0] i_word,
  output logic o_sdi,
  output logic o_sclk,
  output logic o_strobe,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sdi = 1'b0;
    o_sclk = 1'b0;
    o_strobe = 1'b0;
    o_busy = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_go) begin
      o_busy <= 1'b1;
      if (i_par) begin
        o_sdi <= i_word[0];
        o_sclk <= i_word[1];
      end else begin
        for (int i = 0; i < 16; i++) begin
          o_sdi <= i_word[i];
          repeat (4) @(posedge i_clk);
          o_sclk <= 1'b1;
          repeat (4) @(posedge i_clk);
          o_sclk <= 1'b0;
        end
        // released data line shows the inverse of its last bit
        o_sdi <= ~i_word[15];
      end
      repeat (4) @(posedge i_clk);
      o_strobe <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_strobe <= 1'b0;
      o_busy <= 1'b0;
    end
  end
endmodule

// *** verif/sac_top_bench.sv ***
module sac_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] w; logic [2:0] st; logic [5:0] e;} sac_row_s;
  logic i_clk, rst, sel, strb_f, park, sdo_in, go, par, awv, wv, bry, arv, rry;
  logic [2:0] strap;
  logic [15:0] word;
  logic [3:0] awa, ara;
  logic [31:0] wd, d;
  logic [1:0] r;
  wire p_sdi, p_sclk, p_strobe, busy, sdo, sdo_oe, awr, wr, bv, arr, rv;
  wire [5:0] code;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] hist = 16'h0000;
  sac_row_s rows [5] = '{
    '{16'h034A, 3'd3, 6'h25}, '{16'h0502, 3'd3, 6'h25}, '{16'h0302, 3'd3, 6'h01},
    '{16'h007E, 3'd0, 6'h3F}, '{16'h0740, 3'd7, 6'h20}};
  sac_ctrl_model u_sac_ctrl_model (.i_clk(i_clk), .i_go(go), .i_par(par), .i_word(word),
    .o_sdi(p_sdi), .o_sclk(p_sclk), .o_strobe(p_strobe), .o_busy(busy));
  sac_top u_sac_top (.i_clk(i_clk), .i_rst(rst), .i_ce(1'b1), .i_serial_select(sel),
    .i_latch_strobe(p_strobe | strb_f), .i_serial_in_or_half_db_bit(p_sdi & ~park),
    .i_serial_clock_or_one_db_bit(p_sclk & ~park), .i_serial_out_or_two_db_bit(sdo_in),
    .i_addr_strap0_or_four_db_bit(strap[0]), .i_addr_strap1_or_eight_db_bit(strap[1]),
    .i_addr_strap2_or_sixteen_db_bit(strap[2]), .o_serial_out_or_two_db_bit(sdo),
    .o_serial_out_or_two_db_bit_oe(sdo_oe), .o_atten_code(code), .i_axi_awaddr(awa),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(4'hF),
    .i_axi_wvalid(wv), .o_axi_wready(wr), .o_axi_bresp(bresp), .o_axi_bvalid(bv),
    .i_axi_bready(bry), .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rv), .i_axi_rready(rry));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task wrap_up;
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // cascade view: output seen at each rise is the input of 16 rises before
  always @(posedge p_sclk) begin
    if (sel === 1'b1) begin
      chk("serial out", {31'h0000_0000, hist[15]}, {31'h0000_0000, sdo});
      hist <= {hist[14:0], p_sdi};
    end
  end
  task axi_wr(input logic [3:0] a, input logic [31:0] v);
    bit pa, pw;
    pa = 1;
    pw = 1;
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    while (pa || pw) begin
      @(posedge i_clk);
      if (pa && awr === 1'b1) begin pa = 0; awv <= 1'b0; end
      if (pw && wr === 1'b1) begin pw = 0; wv <= 1'b0; end
    end
    do @(posedge i_clk); while (bv !== 1'b1);
    r = bresp;
    bry <= 1'b0;
    @(posedge i_clk);
  endtask
  task axi_rd(input logic [3:0] a);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do @(posedge i_clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge i_clk); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rry <= 1'b0;
    @(posedge i_clk);
  endtask
  task send(input logic p, input logic [15:0] w);
    par <= p; word <= w; go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    do @(posedge i_clk); while (busy === 1'b1);
    repeat (8) @(posedge i_clk);
  endtask
  initial begin
    {rst, sel, strb_f, park, sdo_in, go, par, awv, wv, bry, arv, rry} = 12'b1100_0000_0000;
    strap = 3'd0; word = 16'h0000; awa = 4'h0; ara = 4'h0; wd = 32'h0000_0000;
    repeat (5) @(posedge i_clk);
    rst <= 1'b0;
    repeat (20) @(posedge i_clk);
    chk("boot code", 32'h3F, code);
    foreach (rows[i]) begin
      strap <= rows[i].st;
      repeat (4) @(posedge i_clk);
      send(1'b0, rows[i].w);
      chk("serial code", rows[i].e, code);
    end
    chk("sdo enable", 32'h1, sdo_oe);
    axi_rd(4'h8);
    chk("shift reg", 32'h0740, d);
    axi_rd(4'h4);
    chk("status", 32'h0000_0320 | 32'h0000_0040, d & 32'h0000_037F);
    axi_rd(4'hC);
    chk("unmapped resp", 32'h2, r);
    chk("unmapped data", 32'h0, d);
    axi_wr(4'h0, 32'h0000_0001);
    chk("ctrl resp", 32'h0, r);
    send(1'b0, 16'h0710);
    chk("frozen code", 32'h20, code);
    axi_rd(4'h0);
    chk("ctrl read", 32'h1, d);
    axi_wr(4'h0, 32'h0000_0000);
    park <= 1'b1;
    strap <= 3'd0;
    repeat (4) @(posedge i_clk);
    sel <= 1'b0;
    park <= 1'b0;
    strap <= 3'd5;
    sdo_in <= 1'b1;
    repeat (4) @(posedge i_clk);
    send(1'b1, 16'h0001);
    chk("latched par", 32'h2D, code);
    chk("par sdo off", 32'h0, sdo_oe);
    strap <= 3'd7;
    repeat (10) @(posedge i_clk);
    chk("par hold", 32'h2D, code);
    strb_f <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk("direct par", 32'h3D, code);
    park <= 1'b1;
    strap <= 3'd0;
    sdo_in <= 1'b0;
    strb_f <= 1'b0;
    repeat (4) @(posedge i_clk);
    sel <= 1'b1;
    repeat (4) @(posedge i_clk);
    rst <= 1'b1;
    park <= 1'b0;
    strb_f <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk("reset code", 32'h3F, code);
    rst <= 1'b0;
    repeat (20) @(posedge i_clk);
    chk("ref start", 32'h00, code);
    rst <= 1'b1;
    sel <= 1'b0;
    strap <= 3'd6;
    repeat (5) @(posedge i_clk);
    rst <= 1'b0;
    repeat (20) @(posedge i_clk);
    chk("direct wait", 32'h3F, code);
    repeat (80) @(posedge i_clk);
    chk("direct start", 32'h31, code);
    wrap_up();
  end
endmodule
